// *** hdl/hah_pkg.sv ***
// constants and types for the host access hazard controller
package hah_pkg;

	localparam int CLK_PERIOD_NS = 100;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int CNT_W = 4;
	localparam int ACCESS_CYC = 3;

	// word addresses (A[7:1]) of the device resources that matter here
	localparam logic [6:0] ADDR_RX_DATA_FIFO = 7'h00;
	localparam logic [6:0] ADDR_TX_DATA_FIFO = 7'h10;
	localparam logic [6:0] ADDR_RX_STS_FIFO = 7'h20;
	localparam logic [6:0] ADDR_TX_STS_FIFO = 7'h24;
	localparam logic [6:0] ADDR_CHIP_IDENTITY = 7'h28;
	localparam logic [6:0] ADDR_IRQ_CONFIG = 7'h2a;
	localparam logic [6:0] ADDR_INTERRUPT_STATUS = 7'h2c;
	localparam logic [6:0] ADDR_BYTE_ORDER_TEST = 7'h32;
	localparam logic [6:0] ADDR_RX_FILL_LEVEL = 7'h3e;
	localparam logic [6:0] ADDR_TX_FILL_LEVEL = 7'h40;
	localparam logic [6:0] ADDR_POWER_MGMT_CTRL = 7'h42;
	localparam logic [6:0] ADDR_GENERAL_TIMER_COUNT = 7'h4a;
	localparam logic [6:0] ADDR_FREE_RUN_COUNT = 7'h4e;
	localparam logic [6:0] ADDR_RX_DROP_COUNT = 7'h50;

	// minimum waits in ns
	localparam int WAIT_45_NS = 45;
	localparam int WAIT_90_NS = 90;
	localparam int WAIT_135_NS = 135;
	localparam int WAIT_180_NS = 180;
	localparam int WAIT_315_NS = 315;

	// least times round up, never below one cycle unless zero
	function automatic logic [CNT_W-1:0] nsToCyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return CNT_W'(c);
	endfunction : nsToCyc

	localparam logic [CNT_W-1:0] CYC_45 = nsToCyc(WAIT_45_NS);
	localparam logic [CNT_W-1:0] CYC_90 = nsToCyc(WAIT_90_NS);
	localparam logic [CNT_W-1:0] CYC_135 = nsToCyc(WAIT_135_NS);
	localparam logic [CNT_W-1:0] CYC_180 = nsToCyc(WAIT_180_NS);
	localparam logic [CNT_W-1:0] CYC_315 = nsToCyc(WAIT_315_NS);

	typedef enum logic [3:0] {
		CLS_NONE = 4'h0,
		CLS_45 = 4'h1,
		CLS_90 = 4'h2,
		CLS_135 = 4'h3,
		CLS_TXFILL = 4'h4,
		CLS_RXFILL = 4'h5,
		CLS_180 = 4'h6,
		CLS_315 = 4'h7,
		CLS_DROP = 4'h8
	} hah_cls_t;

	localparam int NCLS = 9;

	// register class of a read target
	function automatic hah_cls_t classOf(input logic [6:0] a, input logic fsel);
		if (fsel)
			return CLS_NONE;
		case (a)
			ADDR_CHIP_IDENTITY, ADDR_BYTE_ORDER_TEST, ADDR_RX_DATA_FIFO,
			ADDR_RX_STS_FIFO, ADDR_TX_STS_FIFO, ADDR_TX_DATA_FIFO: return CLS_NONE;
			ADDR_IRQ_CONFIG, ADDR_GENERAL_TIMER_COUNT: return CLS_135;
			ADDR_INTERRUPT_STATUS: return CLS_90;
			ADDR_TX_FILL_LEVEL: return CLS_TXFILL;
			ADDR_RX_FILL_LEVEL: return CLS_RXFILL;
			ADDR_FREE_RUN_COUNT: return CLS_180;
			ADDR_POWER_MGMT_CTRL: return CLS_315;
			ADDR_RX_DROP_COUNT: return CLS_DROP;
			default: return CLS_45;
		endcase
	endfunction : classOf

	// wait after any write, per class
	function automatic logic [CNT_W-1:0] writeWait(input int c);
		case (c)
			int'(CLS_45): return CYC_45;
			int'(CLS_90): return CYC_90;
			int'(CLS_135), int'(CLS_TXFILL): return CYC_135;
			int'(CLS_180): return CYC_180;
			int'(CLS_315): return CYC_315;
			default: return '0;
		endcase
	endfunction : writeWait

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ACCESS = 3'b010,
		ST_RECOVER = 3'b100
	} hah_state_t;

endpackage : hah_pkg

// *** hdl/hah_hazard_if.sv ***
// carrier between the pin sequencer and the hazard timers
`timescale 1ns/100ps
`default_nettype none
interface hah_hazard_if;
	import hah_pkg::*;
	logic ldWrite;
	logic ldRxPop;
	logic ldTxStsPop;
	logic ldDrop;
	hah_cls_t queryCls;
	logic busy;
	modport seq (output ldWrite, output ldRxPop, output ldTxStsPop, output ldDrop,
		output queryCls, input busy);
	modport tmr (input ldWrite, input ldRxPop, input ldTxStsPop, input ldDrop,
		input queryCls, output busy);
endinterface : hah_hazard_if
`default_nettype wire

// *** hdl/hah_hazard_timer.sv ***
// per-class countdowns of the remaining read hazard
`timescale 1ns/100ps
`default_nettype none
module hah_hazard_timer (
	input wire logic clock,
	input wire logic srst,
	hah_hazard_if.tmr hz
);
	import hah_pkg::*;

	logic [CNT_W-1:0] cnt_q [NCLS];
	logic [CNT_W-1:0] cnt_d [NCLS];

	always_comb
	begin
		for (int c = 0; c < NCLS; c++)
		begin
			cnt_d[c] = (cnt_q[c] != '0) ? cnt_q[c] - 1'b1 : '0;
			// loads take the larger of old and new so no hazard is shortened
			if (hz.ldWrite && writeWait(c) > cnt_d[c])
				cnt_d[c] = writeWait(c);
		end
		if (hz.ldRxPop && CYC_135 > cnt_d[CLS_RXFILL])
			cnt_d[CLS_RXFILL] = CYC_135;
		if (hz.ldTxStsPop && CYC_135 > cnt_d[CLS_TXFILL])
			cnt_d[CLS_TXFILL] = CYC_135;
		if (hz.ldDrop)
			cnt_d[CLS_DROP] = CYC_180;
	end

	always_ff @(posedge clock)
	begin
		for (int c = 0; c < NCLS; c++)
			cnt_q[c] <= srst ? '0 : cnt_d[c];
	end

	// elapsed time is counted directly, so no spacer reads are needed
	assign hz.busy = cnt_q[hz.queryCls] != '0;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	pwr_wait_a: assert property (hz.ldWrite |=> cnt_q[CLS_315] == CYC_315)
		else $error("power mgmt wait not loaded");
	cfg_wait_a: assert property (hz.ldWrite |=> cnt_q[CLS_135] == CYC_135
		&& cnt_q[CLS_TXFILL] == CYC_135)
		else $error("135ns class wait not loaded");
	short_wait_a: assert property (hz.ldWrite |=> cnt_q[CLS_45] == CYC_45
		&& cnt_q[CLS_90] == CYC_90 && cnt_q[CLS_180] == CYC_180)
		else $error("short class waits wrong");
	rx_pop_a: assert property (hz.ldRxPop |=> cnt_q[CLS_RXFILL] == CYC_135)
		else $error("rx fill hazard not loaded");
	tx_pop_a: assert property (hz.ldTxStsPop |=> cnt_q[CLS_TXFILL] >= CYC_135)
		else $error("tx fill hazard not loaded");
	drop_gap_a: assert property (hz.ldDrop |=> hz.queryCls != CLS_DROP || hz.busy)
		else $error("drop count reread too early");

endmodule : hah_hazard_timer
`default_nettype wire

// *** hdl/hah_host_ctrl.sv ***
// host-side controller driving the device's 16-bit strobe port
//
// Functional notes
// - four read kinds: register, burst, rx fifo direct, rx fifo direct burst.
// - two write kinds: register writes and tx data fifo writes.
// - after a write, next read waits the target register's own minimum.
// - irq config, tx fill and timer count need 135 ns after writes.
// - interrupt status 90 ns, free-run 180 ns, power mgmt 315 ns.
// - other config registers 45 ns; identity, test, rx fill, drop none.
// - spacer byte-test reads may fill a gap; counts assume 45 ns.
// - slower hosts need fewer spacers; only elapsed time matters.
// - after rx data or status pop, wait 135 ns before rx fill.
// - after tx status pop, wait 135 ns before tx fill.
// - two rx drop count reads at least 180 ns apart.
// - read runs while select and read strobe both low.
`timescale 1ns/100ps
`default_nettype none
module hah_host_ctrl (
	input wire logic clock,
	input wire logic srst,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic cmdWrite,
	input wire logic cmdFifoSel,
	input wire logic [hah_pkg::ADDR_W-1:0] cmdAddr,
	input wire logic [hah_pkg::DATA_W-1:0] cmdData,
	output logic rspValid,
	output logic [hah_pkg::DATA_W-1:0] rspData,
	output logic chipSelectN,
	output logic readStrobeN,
	output logic writeStrobeN,
	output logic fifoSel,
	output logic [hah_pkg::ADDR_W-1:0] addrOut,
	output logic [hah_pkg::DATA_W-1:0] dataOut,
	output logic dataOe,
	input wire logic [hah_pkg::DATA_W-1:0] dataIn
);
	import hah_pkg::*;

	hah_state_t state_q;
	hah_state_t state_d;
	logic [1:0] accCnt_q;
	logic isWrite_q;
	logic [DATA_W-1:0] dataInS1_q;
	logic [DATA_W-1:0] dataInS2_q;
	logic [CNT_W-1:0] sinceWr_q;
	logic rspValid_q;
	logic [DATA_W-1:0] rspData_q;

	hah_hazard_if hz ();

	hah_hazard_timer u_timer (
		.clock(clock),
		.srst(srst),
		.hz(hz.tmr)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode

	wire logic accLast = state_q == ST_ACCESS && accCnt_q == 2'(ACCESS_CYC - 1);
	wire logic isRxPop = fifoSel || addrOut == ADDR_RX_DATA_FIFO
		|| addrOut == ADDR_RX_STS_FIFO;
	wire logic accept = cmdValid && cmdReady;

	assign hz.queryCls = cmdWrite ? CLS_NONE : classOf(cmdAddr, cmdFifoSel);
	// reads stall while their class still has hazard time left
	assign cmdReady = state_q == ST_IDLE && !hz.busy;
	assign hz.ldWrite = accLast && isWrite_q;
	assign hz.ldRxPop = accLast && !isWrite_q && isRxPop;
	assign hz.ldTxStsPop = accLast && !isWrite_q && !fifoSel
		&& addrOut == ADDR_TX_STS_FIFO;
	assign hz.ldDrop = accLast && !isWrite_q && !fifoSel
		&& addrOut == ADDR_RX_DROP_COUNT;
	assign rspValid = rspValid_q;
	assign rspData = rspData_q;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: if (accept) state_d = ST_ACCESS;
			ST_ACCESS: if (accLast) state_d = ST_RECOVER;
			ST_RECOVER: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge clock)
	begin
		if (srst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clock)
	begin
		if (srst || state_q != ST_ACCESS)
			accCnt_q <= '0;
		else
			accCnt_q <= accCnt_q + 2'h1;
	end

	// address and data launch with the strobes; held through recovery
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			addrOut <= '0;
			fifoSel <= 1'b0;
			dataOut <= '0;
			isWrite_q <= 1'b0;
		end
		else if (accept)
		begin
			addrOut <= cmdAddr;
			fifoSel <= cmdFifoSel;
			dataOut <= cmdData;
			isWrite_q <= cmdWrite;
		end
	end

	// select plus one strobe, released together so one edge ends the cycle
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			chipSelectN <= 1'b1;
			readStrobeN <= 1'b1;
			writeStrobeN <= 1'b1;
		end
		else
		begin
			chipSelectN <= !(state_d == ST_ACCESS);
			readStrobeN <= !(state_d == ST_ACCESS && !(accept ? cmdWrite : isWrite_q));
			writeStrobeN <= !(state_d == ST_ACCESS && (accept ? cmdWrite : isWrite_q));
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			dataOe <= 1'b0;
		else
			dataOe <= state_d != ST_IDLE && (accept ? cmdWrite : isWrite_q);
	end

	////////////////////////////////////////////////////////////////////////////
	// read data capture

	// bus holds steady while strobed, so the synchroniser settles in time
	always_ff @(posedge clock)
	begin
		dataInS1_q <= dataIn;
		dataInS2_q <= dataInS1_q;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			rspValid_q <= 1'b0;
			rspData_q <= '0;
		end
		else
		begin
			rspValid_q <= accLast && !isWrite_q;
			if (accLast && !isWrite_q)
				rspData_q <= dataInS2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	always_ff @(posedge clock)
	begin
		if (srst)
			sinceWr_q <= '1;
		else if (hz.ldWrite)
			sinceWr_q <= '0;
		else if (sinceWr_q != '1)
			sinceWr_q <= sinceWr_q + 1'b1;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	strobe_excl_a: assert property (!(!readStrobeN && !writeStrobeN))
		else $error("read and write strobes both active");
	read_width_a: assert property ($fell(readStrobeN) |-> !chipSelectN [*3])
		else $error("read strobe window too short");
	pwr_after_wr_a: assert property ($fell(readStrobeN) && !fifoSel
		&& addrOut == ADDR_POWER_MGMT_CTRL |-> sinceWr_q >= CYC_315)
		else $error("power mgmt read too soon after write");
	txfill_after_wr_a: assert property ($fell(readStrobeN) && !fifoSel
		&& addrOut == ADDR_TX_FILL_LEVEL |-> sinceWr_q >= CYC_135)
		else $error("tx fill read too soon after write");
	stall_busy_a: assert property (state_q == ST_IDLE && hz.busy |-> !cmdReady
		##1 chipSelectN)
		else $error("read issued during hazard");
	write_oe_a: assert property (!writeStrobeN |-> dataOe)
		else $error("write strobe without bus drive");
	read_oe_a: assert property (!readStrobeN |-> !dataOe)
		else $error("host drives bus during read");
	rsp_pulse_a: assert property (rspValid |=> !rspValid)
		else $error("response valid longer than one cycle");
	addr_hold_a: assert property (!chipSelectN && !$past(chipSelectN)
		|-> $stable(addrOut) && $stable(fifoSel))
		else $error("address moved inside an access");
	idle_pins_a: assert property (state_q == ST_IDLE
		|-> chipSelectN && readStrobeN && writeStrobeN)
		else $error("strobe active while idle");

endmodule : hah_host_ctrl
`default_nettype wire

// *** sim/hah_dev_model.sv ***
// behavioural device on the far side of the host strobe port
`timescale 1ns/100ps
`default_nettype none
module hah_dev_model (
	input wire logic clock,
	input wire logic chipSelectN,
	input wire logic readStrobeN,
	input wire logic writeStrobeN,
	input wire logic fifoSel,
	input wire logic [hah_pkg::ADDR_W-1:0] addrOut,
	input wire logic [hah_pkg::DATA_W-1:0] dataOut,
	output logic [hah_pkg::DATA_W-1:0] dataIn,
	output logic [hah_pkg::DATA_W-1:0] lastWrite,
	output int errCount
);
	import hah_pkg::*;
	logic rdAct, wrAct, rdPrev = 1'b0, wrPrev = 1'b0, fsQ = 1'b0, bad;
	logic [ADDR_W-1:0] aQ = '0;
	logic [DATA_W-1:0] held = '0;
	realtime wrEnd = -1000.0, rxPopEnd = -1000.0, txPopEnd = -1000.0, dropEnd = -1000.0;
	realtime w, now;
	int errs = 0;
	logic [DATA_W-1:0] lastWr = '0;
	assign errCount = errs;
	assign lastWrite = lastWr;
	// both strobes low frame the access, in either order
	assign rdAct = !chipSelectN && !readStrobeN;
	assign wrAct = !chipSelectN && !writeStrobeN;
	// released bus shows the inverse of the last word so a late sample never looks valid
	assign dataIn = rdAct ? {fifoSel ? 9'h0f0 : 9'h1a5, addrOut} : ~held;
	/////////////////////////////////////////////////////////////////////////////
	always @(posedge clock)
	begin
		now = $realtime;
		rdPrev <= rdAct;
		wrPrev <= wrAct;
		if (rdAct)
			held <= dataIn;
		if (wrAct && !wrPrev)
			lastWr <= dataOut;
		if (!wrAct && wrPrev)
			wrEnd = now;
		if (rdAct && !rdPrev)
		begin
			aQ <= addrOut;
			fsQ <= fifoSel;
			case (addrOut)
				ADDR_IRQ_CONFIG, ADDR_TX_FILL_LEVEL, ADDR_GENERAL_TIMER_COUNT: w = 135;
				ADDR_INTERRUPT_STATUS: w = 90;
				ADDR_FREE_RUN_COUNT: w = 180;
				ADDR_POWER_MGMT_CTRL: w = 315;
				ADDR_CHIP_IDENTITY, ADDR_BYTE_ORDER_TEST, ADDR_RX_FILL_LEVEL, ADDR_RX_DROP_COUNT,
				ADDR_RX_DATA_FIFO, ADDR_RX_STS_FIFO, ADDR_TX_STS_FIFO: w = 0;
				default: w = 45;
			endcase
			if (fifoSel)
				w = 0;
			bad = (now - wrEnd < w);
			bad |= !fifoSel && addrOut == ADDR_RX_FILL_LEVEL && now - rxPopEnd < 135;
			bad |= !fifoSel && addrOut == ADDR_TX_FILL_LEVEL && now - txPopEnd < 135;
			bad |= !fifoSel && addrOut == ADDR_RX_DROP_COUNT && now - dropEnd < 180;
			if (bad)
				errs <= errs + 1;
		end
		// levels settle only some time after a popping read ends
		if (!rdAct && rdPrev)
		begin
			if (fsQ || aQ == ADDR_RX_DATA_FIFO || aQ == ADDR_RX_STS_FIFO)
				rxPopEnd = now;
			if (!fsQ && aQ == ADDR_TX_STS_FIFO)
				txPopEnd = now;
			if (!fsQ && aQ == ADDR_RX_DROP_COUNT)
				dropEnd = now;
		end
	end
endmodule : hah_dev_model
`default_nettype wire

// *** sim/tb_hah_host_ctrl.sv ***
// self-checking bench for the host access hazard controller
`timescale 1ns/100ps
`default_nettype none
module tb_hah_host_ctrl;
	import hah_pkg::*;
	logic clock = 0, srst = 1, cmdValid = 0, cmdWrite = 0, cmdFifoSel = 0;
	logic [ADDR_W-1:0] cmdAddr = '0, addrOut;
	logic [DATA_W-1:0] cmdData = '0, rspData, dataOut, dataIn, lastWrite;
	logic cmdReady, rspValid, chipSelectN, readStrobeN, writeStrobeN, fifoSel, dataOe;
	int errCount, mismatches = 0, cmpCount = 0, cyc = 0, takeAt = 0;
	hah_host_ctrl dut (.clock(clock), .srst(srst), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdWrite(cmdWrite), .cmdFifoSel(cmdFifoSel), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.rspValid(rspValid), .rspData(rspData), .chipSelectN(chipSelectN),
		.readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .fifoSel(fifoSel),
		.addrOut(addrOut), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
	hah_dev_model dev (.clock(clock), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
		.writeStrobeN(writeStrobeN), .fifoSel(fifoSel), .addrOut(addrOut), .dataOut(dataOut),
		.dataIn(dataIn), .lastWrite(lastWrite), .errCount(errCount));
	initial forever #50 clock = ~clock;
	/////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	task automatic check(input logic ok, input string msg);
		cmpCount++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("Error %0t: %s", $time, msg);
		end
	endtask : check
	// one command; gap is cycles since the previous take
	task automatic access(input logic w, input logic fs, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic waitRsp, output int gap);
		int n;
		@(posedge clock);
		cmdValid <= 1'b1;
		cmdWrite <= w;
		cmdFifoSel <= fs;
		cmdAddr <= a;
		cmdData <= d;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (cmdReady !== 1'b1 && n < 50);
		cmdValid <= 1'b0;
		gap = cyc - takeAt;
		takeAt = cyc;
		check(n < 50, "command never taken");
		n = 0;
		if (w)
		begin
			repeat (3) @(posedge clock);
			check(lastWrite === d && dataOe === 1'b1, "write data on bus");
		end
		else if (waitRsp)
		begin
			do
			begin
				@(posedge clock);
				n++;
			end
			while (rspValid !== 1'b1 && n < 8);
			check(n == 4 && rspData === {fs ? 9'h0f0 : 9'h1a5, a}, "read data");
			@(posedge clock);
			check(rspValid === 1'b0 && dataOe === 1'b0, "response pulse too long");
		end
	endtask : access
	/////////////////////////////////////////////////////////////////////////////
	task automatic writeThenRead();
		logic [ADDR_W-1:0] tgt [11] = '{ADDR_IRQ_CONFIG, ADDR_INTERRUPT_STATUS,
			ADDR_TX_FILL_LEVEL, ADDR_POWER_MGMT_CTRL, ADDR_FREE_RUN_COUNT,
			ADDR_GENERAL_TIMER_COUNT, 7'h36, ADDR_CHIP_IDENTITY, ADDR_BYTE_ORDER_TEST,
			ADDR_RX_FILL_LEVEL, ADDR_RX_DROP_COUNT};
		int ns [11] = '{135, 90, 135, 315, 180, 135, 45, 0, 0, 0, 0};
		int g;
		for (int i = 0; i < 11; i++)
		begin
			access(1'b1, 1'b0, i[0] ? ADDR_TX_DATA_FIFO : 7'h36, 16'h5a00 + 16'(i), 1'b1, g);
			access(1'b0, 1'b0, tgt[i], '0, 1'b1, g);
			check(errCount === 0 && g <= 6 + (ns[i] + 99) / 100, "write to read spacing");
			if (ns[i] == 0)
				check(g == 5, "needless stall after write");
		end
		$display("test write then read done");
	endtask : writeThenRead
	task automatic popThenRead();
		logic [ADDR_W-1:0] first [4] = '{ADDR_RX_DATA_FIFO, ADDR_RX_STS_FIFO,
			ADDR_TX_STS_FIFO, ADDR_RX_DROP_COUNT};
		logic [ADDR_W-1:0] second [4] = '{ADDR_RX_FILL_LEVEL, ADDR_RX_FILL_LEVEL,
			ADDR_TX_FILL_LEVEL, ADDR_RX_DROP_COUNT};
		int g;
		for (int i = 0; i < 4; i++)
		begin
			access(1'b0, i == 0, first[i], '0, 1'b0, g);
			access(1'b0, 1'b0, second[i], '0, 1'b1, g);
			check(errCount === 0 && g <= 8, "read to read spacing");
		end
		$display("test pop then read done");
	endtask : popThenRead
	task automatic burstRead();
		int g;
		for (int i = 0; i < 4; i++)
		begin
			access(1'b0, 1'b1, 7'(i), '0, i == 3, g);
			if (i > 0)
				check(g == 5, "direct burst spacing");
		end
		check(errCount === 0, "burst hazard");
		$display("test burst read done");
	endtask : burstRead
	/////////////////////////////////////////////////////////////////////////////
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			mismatches++;
			$display("Error %0t: timeout", $time);
			summarize();
		end
	end
	initial
	begin
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		check(chipSelectN === 1'b1 && dataOe === 1'b0 && cmdReady === 1'b1
			&& rspValid === 1'b0, "idle after reset");
		writeThenRead();
		popThenRead();
		burstRead();
		summarize();
	end
endmodule : tb_hah_host_ctrl
`default_nettype wire
